// ### logic/amcfa_pkg.sv
// Shared constants and types for the mode, link setup and lane alarm block.
// Assumes one 20 MHz clock and plain configuration ports, no register bus.
package amcfa_pkg;

  localparam int NUM_LANES = 16;
  localparam int MODE_W = 5;
  localparam int KM1_W = 8;

  // Reinit pulse length, in device clock cycles
  localparam int REINIT_CYC = 8;
  localparam int REINIT_CNT_W = 4;

  // Input mux select codes for single channel operation
  localparam logic [1:0] SEL_INA = 2'h0;
  localparam logic [1:0] SEL_INB = 2'h1;
  localparam logic [1:0] SEL_BOTH = 2'h2;

  // Analog input identifiers on the channel routing outputs
  localparam logic IN_A = 1'h0;
  localparam logic IN_B = 1'h1;

  // Reset values
  localparam logic SWAP_RST = 1'h0;
  localparam logic [1:0] SEL_RST = 2'h0;
  localparam logic [KM1_W-1:0] KM1_RST = 8'h1f;

  // Fixed extended multiblock count
  localparam logic [1:0] E_FIXED = 2'h1;

  // Derived link setup carried as one word
  typedef struct packed {
    logic valid;
    logic des;
    logic enc_64;
    logic [5:0] r_x4;
    logic [1:0] links;
    logic [4:0] lanes;
    logic [3:0] convs;
    logic [3:0] octets;
    logic [3:0] samples;
    logic [3:0] res_bits;
    logic [3:0] nprime;
    logic [1:0] cs;
  } amcfa_link_s;

  typedef enum logic {
    RI_IDLE = 1'b0,
    RI_BUSY = 1'b1
  } amcfa_reinit_e;

endpackage

// ### logic/amcfa_lane_alarm.sv
// One sticky buffer alarm bit for a single serializer lane.
// Assumes event and clear strobes are synchronous one-cycle pulses.
module amcfa_lane_alarm (
  input wire logic clock,
  input wire logic rst,
  input wire logic upset,
  input wire logic clear,
  output logic alarm
);

  logic alarm_ff;

  // Set wins over a clear in the same cycle
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      alarm_ff <= 1'h0;
    end else if (upset) begin
      alarm_ff <= 1'h1;
    end else if (clear) begin
      alarm_ff <= 1'h0;
    end
  end

  assign alarm = alarm_ff;

endmodule

// ### logic/amcfa_mode_decode.sv
// Mode code to link transport parameter lookup.
// Assumes codes outside the table are reserved and flag invalid.
module amcfa_mode_decode (
  input wire logic [amcfa_pkg::MODE_W-1:0] mode,
  output amcfa_pkg::amcfa_link_s cfg
);

  // Purely combinational table; codes without a row read as invalid
  always_comb begin
    cfg = '0;
    unique case (mode)
      5'h00: cfg = '{1'h1, 1'h1, 1'h0, 6'h10, 2'h2, 5'h04, 4'h4,
                     4'h8, 4'h5, 4'hc, 4'hc, 2'h0};
      5'h01: cfg = '{1'h1, 1'h1, 1'h0, 6'h08, 2'h2, 5'h08, 4'h8,
                     4'h8, 4'h5, 4'hc, 4'hc, 2'h0};
      5'h02: cfg = '{1'h1, 1'h0, 1'h0, 6'h10, 2'h2, 5'h04, 4'h4,
                     4'h8, 4'h5, 4'hc, 4'hc, 2'h0};
      5'h03: cfg = '{1'h1, 1'h0, 1'h0, 6'h08, 2'h2, 5'h08, 4'h8,
                     4'h8, 4'h5, 4'hc, 4'hc, 2'h0};
      5'h05: cfg = '{1'h1, 1'h1, 1'h0, 6'h0a, 2'h2, 5'h04, 4'h1,
                     4'h1, 4'h4, 4'h8, 4'h8, 2'h0};
      5'h06: cfg = '{1'h1, 1'h1, 1'h0, 6'h05, 2'h2, 5'h08, 4'h1,
                     4'h1, 4'h8, 4'h8, 4'h8, 2'h0};
      default: cfg = '0;
    endcase
  end

endmodule

// ### logic/amcfa_mode_cfg_fifo_alarm.sv
// Top of the mode selection, link setup and lane buffer alarm block.
// Assumes all control inputs are synchronous to the 20 MHz clock and
// that lane upset inputs are one-cycle pulses from the buffer logic.
module amcfa_mode_cfg_fifo_alarm #(
  parameter int NUM_LANES = amcfa_pkg::NUM_LANES
) (
  input wire logic clock,
  input wire logic rst,
  // Configuration controls
  input wire logic [amcfa_pkg::MODE_W-1:0] link_mode_select,
  input wire logic link_enable,
  input wire logic [amcfa_pkg::KM1_W-1:0] frames_per_multiframe_minus_one,
  input wire logic auto_reinit_on_buffer_alarm,
  input wire logic input_swap,
  input wire logic [1:0] single_input_select,
  input wire logic cal_done,
  // Lane buffer upset events
  input wire logic [NUM_LANES-1:0] lane_overflow,
  input wire logic [NUM_LANES-1:0] lane_underflow,
  // Alarm clear, write one to clear
  input wire logic alarm_clear_wr,
  input wire logic [NUM_LANES-1:0] alarm_clear_bits,
  // Alarm status
  output logic lane_buffer_alarm,
  output logic [NUM_LANES-1:0] per_lane_buffer_alarm,
  // Reinit and power control
  output logic serializer_reinit,
  output logic buffer_reinit,
  output logic link_block_reset,
  output logic serializer_power_down,
  // Derived link setup
  output amcfa_pkg::amcfa_link_s link_cfg,
  output logic [8:0] frames_per_multiframe,
  output logic [1:0] multiblocks_per_emb,
  output logic ilas_enable,
  output logic [5:0] pll_mult_x4,
  output logic pll_bypass,
  // Channel routing
  output logic interleave,
  output logic sample_rate_double,
  output logic ch_a_input,
  output logic ch_b_input,
  output logic ch_b_out_of_phase
);

  logic [NUM_LANES-1:0] lane_upset;
  logic [NUM_LANES-1:0] lane_alarm;
  logic any_upset;
  amcfa_pkg::amcfa_link_s dec_cfg;
  amcfa_pkg::amcfa_link_s cfg_ff;
  logic [amcfa_pkg::KM1_W-1:0] km1_ff;
  amcfa_pkg::amcfa_reinit_e reinit_state_ff;
  amcfa_pkg::amcfa_reinit_e nxt_reinit_state;
  logic [amcfa_pkg::REINIT_CNT_W-1:0] reinit_cnt_ff;
  logic [amcfa_pkg::REINIT_CNT_W-1:0] nxt_reinit_cnt;
  logic swap_ff;
  logic [1:0] sel_ff;
  logic route_a_ff;
  logic route_b_ff;
  logic reinit_go;

  // Any lane overflow or underflow counts as a buffer upset
  assign lane_upset = lane_overflow | lane_underflow;
  assign any_upset = |lane_upset;

  // One sticky alarm per lane, cleared only by a one written to it
  for (genvar i = 0; i < NUM_LANES; i++) begin : g_lane
    amcfa_lane_alarm u_alarm (
      .clock(clock),
      .rst(rst),
      .upset(lane_upset[i]),
      .clear(alarm_clear_wr & alarm_clear_bits[i]),
      .alarm(lane_alarm[i])
    );
  end

  // Summary follows the lane bits so it cannot disagree with them
  assign per_lane_buffer_alarm = lane_alarm;
  assign lane_buffer_alarm = |lane_alarm;

  // Mode code lookup
  amcfa_mode_decode u_decode (
    .mode(link_mode_select),
    .cfg(dec_cfg)
  );

  // Link setup follows the mode code only while the link is off, so a
  // code change under a running link cannot tear the lane format.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cfg_ff <= '0;
      km1_ff <= amcfa_pkg::KM1_RST;
    end else if (!link_enable) begin
      cfg_ff <= dec_cfg;
      km1_ff <= frames_per_multiframe_minus_one;
    end
  end

  // Reinit trigger: new upset with auto reinit on and the link up
  assign reinit_go = auto_reinit_on_buffer_alarm & link_enable
                     & any_upset;

  // Reinit sequencer; upsets during a reinit are caused by it, so they
  // only latch alarms and do not restart the sequence.
  always_comb begin
    nxt_reinit_state = reinit_state_ff;
    nxt_reinit_cnt = reinit_cnt_ff;
    unique case (reinit_state_ff)
      amcfa_pkg::RI_IDLE: begin
        if (reinit_go) begin
          nxt_reinit_state = amcfa_pkg::RI_BUSY;
          nxt_reinit_cnt = amcfa_pkg::REINIT_CNT_W'(amcfa_pkg::REINIT_CYC - 1);
        end
      end
      amcfa_pkg::RI_BUSY: begin
        if (!link_enable || reinit_cnt_ff == '0) begin
          nxt_reinit_state = amcfa_pkg::RI_IDLE;
        end else begin
          nxt_reinit_cnt = reinit_cnt_ff - 1'b1;
        end
      end
    endcase
  end

  // Sequencer state
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      reinit_state_ff <= amcfa_pkg::RI_IDLE;
      reinit_cnt_ff <= '0;
    end else begin
      reinit_state_ff <= nxt_reinit_state;
      reinit_cnt_ff <= nxt_reinit_cnt;
    end
  end

  // Serializers, buffer and link block all restart together
  assign serializer_reinit = (reinit_state_ff == amcfa_pkg::RI_BUSY);
  assign buffer_reinit = serializer_reinit;

  // Link off holds the link block in reset and the lanes powered down
  assign link_block_reset = !link_enable | serializer_reinit;
  assign serializer_power_down = !link_enable;

  // Derived link outputs
  assign link_cfg = cfg_ff;
  assign interleave = cfg_ff.des;
  assign sample_rate_double = cfg_ff.des;
  assign pll_mult_x4 = cfg_ff.r_x4;
  // A ratio of one needs no multiplication
  assign pll_bypass = (cfg_ff.r_x4 == 6'h04);

  // K only means something with 8b10b; E is fixed and only for 64b66b
  assign frames_per_multiframe = cfg_ff.enc_64 ? 9'h000
                                 : {1'b0, km1_ff} + 9'h001;
  assign multiblocks_per_emb = cfg_ff.enc_64 ? amcfa_pkg::E_FIXED
                               : 2'h0;

  // Alignment sequence carries parameters in 8b10b, absent in 64b66b
  assign ilas_enable = !link_block_reset & cfg_ff.valid
                       & !cfg_ff.enc_64;

  // Mux controls only take hold when a calibration completes, since
  // the converter trim is tied to the input it was calibrated on.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      swap_ff <= amcfa_pkg::SWAP_RST;
      sel_ff <= amcfa_pkg::SEL_RST;
    end else if (cal_done) begin
      swap_ff <= input_swap;
      sel_ff <= single_input_select;
    end
  end

  // Channel routing from the effective mode and the held mux setting
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      route_a_ff <= amcfa_pkg::IN_A;
      route_b_ff <= amcfa_pkg::IN_B;
    end else if (!cfg_ff.des) begin
      // Two channels, each on its own input, optionally crossed
      route_a_ff <= swap_ff ? amcfa_pkg::IN_B : amcfa_pkg::IN_A;
      route_b_ff <= swap_ff ? amcfa_pkg::IN_A : amcfa_pkg::IN_B;
    end else if (sel_ff == amcfa_pkg::SEL_BOTH) begin
      // Dual-input interleave: separate inputs, same link format
      route_a_ff <= amcfa_pkg::IN_A;
      route_b_ff <= amcfa_pkg::IN_B;
    end else begin
      // Both channels on the selected input; reserved code falls to A
      route_a_ff <= (sel_ff == amcfa_pkg::SEL_INB);
      route_b_ff <= (sel_ff == amcfa_pkg::SEL_INB);
    end
  end

  assign ch_a_input = route_a_ff;
  assign ch_b_input = route_b_ff;
  // Interleaving runs the second channel on the opposite clock phase
  assign ch_b_out_of_phase = cfg_ff.des;

  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  property p_lane_set;
    (lane_upset != '0) |=>
      ((per_lane_buffer_alarm & $past(lane_upset)) == $past(lane_upset));
  endproperty
  a_lane_set: assert property (p_lane_set)
    else $error("Lane upset did not set its alarm bit");

  property p_summary;
    any_upset |=> lane_buffer_alarm ##0 (per_lane_buffer_alarm != '0);
  endproperty
  a_summary: assert property (p_summary)
    else $error("Summary alarm missing after lane upset");

  property p_sticky;
    per_lane_buffer_alarm[0] && !(alarm_clear_wr && alarm_clear_bits[0])
      |=> per_lane_buffer_alarm[0];
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("Lane alarm dropped without a clear");

  property p_clear;
    alarm_clear_wr && alarm_clear_bits[0] && !lane_upset[0]
      |=> !per_lane_buffer_alarm[0];
  endproperty
  a_clear: assert property (p_clear)
    else $error("Write one did not clear lane alarm");

  property p_or;
    (per_lane_buffer_alarm == '0) |-> !lane_buffer_alarm;
  endproperty
  a_or: assert property (p_or)
    else $error("Summary alarm set with no lane bit");

  // Link held up through the pulse: still busy at its 7th and 8th cycle,
  // idle on the 9th. An earlier drop of the link is allowed to cut it.
  property p_reinit;
    !serializer_reinit && reinit_go ##1 link_enable[*7]
      |-> serializer_reinit ##1 serializer_reinit ##1 !serializer_reinit;
  endproperty
  a_reinit: assert property (p_reinit)
    else $error("Reinit pulse length wrong");

  property p_no_reinit;
    !auto_reinit_on_buffer_alarm && !serializer_reinit
      |=> !serializer_reinit;
  endproperty
  a_no_reinit: assert property (p_no_reinit)
    else $error("Reinit without auto reinit enabled");

  property p_link_off;
    !link_enable |-> link_block_reset && serializer_power_down
      && !ilas_enable;
  endproperty
  a_link_off: assert property (p_link_off)
    else $error("Link not held in reset while disabled");

  property p_des;
    !link_enable |=> interleave == $past(dec_cfg.des);
  endproperty
  a_des: assert property (p_des)
    else $error("Interleave flag does not follow mode code");

  property p_k;
    cfg_ff.enc_64 ? (frames_per_multiframe == 9'h000)
      : (frames_per_multiframe == {1'b0, km1_ff} + 9'h001);
  endproperty
  a_k: assert property (p_k)
    else $error("Frames per multiframe wrong for encoding");

  property p_e;
    !cfg_ff.enc_64 |-> multiblocks_per_emb == 2'h0;
  endproperty
  a_e: assert property (p_e)
    else $error("Extended multiblock count used in 8b10b");

  property p_dual;
    !cfg_ff.des ##1 !$past(cfg_ff.des) |->
      ch_a_input == $past(swap_ff) && ch_b_input != ch_a_input;
  endproperty
  a_dual: assert property (p_dual)
    else $error("Dual channel routing wrong");

  property p_both;
    cfg_ff.des && sel_ff == amcfa_pkg::SEL_BOTH |=>
      (!cfg_ff.des || sel_ff != amcfa_pkg::SEL_BOTH ||
       (ch_a_input != ch_b_input && ch_b_out_of_phase));
  endproperty
  a_both: assert property (p_both)
    else $error("Dual-input interleave routing wrong");

  property p_mux_hold;
    !cal_done |=> $stable(sel_ff) && $stable(swap_ff);
  endproperty
  a_mux_hold: assert property (p_mux_hold)
    else $error("Mux changed without calibration");

  property p_reinit_start;
    !serializer_reinit && reinit_go |=>
      serializer_reinit && buffer_reinit && link_block_reset;
  endproperty
  a_reinit_start: assert property (p_reinit_start)
    else $error("Reinit did not start after buffer alarm");

  property p_reinit_stop;
    serializer_reinit && !link_enable |=> !serializer_reinit;
  endproperty
  a_reinit_stop: assert property (p_reinit_stop)
    else $error("Reinit kept running with link disabled");

  property p_swap;
    !cfg_ff.des && swap_ff |=>
      ch_a_input == amcfa_pkg::IN_B && ch_b_input == amcfa_pkg::IN_A;
  endproperty
  a_swap: assert property (p_swap)
    else $error("Swapped dual routing wrong");

  property p_single_b;
    cfg_ff.des && sel_ff == amcfa_pkg::SEL_INB |=>
      ch_a_input == amcfa_pkg::IN_B && ch_b_input == amcfa_pkg::IN_B;
  endproperty
  a_single_b: assert property (p_single_b)
    else $error("Single mode not on second input");

  property p_single_a;
    cfg_ff.des && sel_ff == amcfa_pkg::SEL_INA |=>
      ch_a_input == amcfa_pkg::IN_A && ch_b_input == amcfa_pkg::IN_A;
  endproperty
  a_single_a: assert property (p_single_a)
    else $error("Single mode not on first input");

  property p_rate;
    interleave |-> sample_rate_double && ch_b_out_of_phase;
  endproperty
  a_rate: assert property (p_rate)
    else $error("Interleave without double rate");

  property p_frozen;
    link_enable |=> $stable(link_cfg);
  endproperty
  a_frozen: assert property (p_frozen)
    else $error("Link setup changed while link running");

  property p_ilas_on;
    link_enable && !serializer_reinit && link_cfg.valid
      && !link_cfg.enc_64 |-> ilas_enable;
  endproperty
  a_ilas_on: assert property (p_ilas_on)
    else $error("Alignment sequence missing in 8b10b");

  c_reinit: cover property (reinit_go ##1 serializer_reinit[*8]);
  c_single_b: cover property (cfg_ff.des && sel_ff == amcfa_pkg::SEL_INB);
  c_both: cover property (cfg_ff.des && sel_ff == amcfa_pkg::SEL_BOTH);
  c_clear: cover property (lane_buffer_alarm ##[1:20] !lane_buffer_alarm);
  c_swap: cover property (!cfg_ff.des && swap_ff);

endmodule

// ### dv/amcfa_rx_model.sv
// Far-end link receiver model: notes alignment sequences it receives.
// Assumes the transmitter's enable and power-down are on the same clock.
module amcfa_rx_model (
  input wire logic clock,
  input wire logic rst,
  input wire logic ilas_enable,
  input wire logic serializer_power_down,
  output logic ilas_seen
);
  timeunit 1ns;
  timeprecision 1ns;

  // Lanes dead while powered down, so alignment is forgotten
  always_ff @(posedge clock or posedge rst) begin
    if (rst || serializer_power_down) begin
      ilas_seen <= 1'h0;
    end else if (ilas_enable) begin
      ilas_seen <= 1'h1;
    end
  end
endmodule

// ### dv/amcfa_mode_cfg_fifo_alarm_tb.sv
// Self-checking bench for the mode, link setup and lane alarm block.
// Assumes the design under logic/ and the receiver model under dv/.
module amcfa_mode_cfg_fifo_alarm_tb;
  timeunit 1ns;
  timeprecision 1ns;

  logic clock, rst, en, auto_ri, swap, cal, clr_wr;
  logic [amcfa_pkg::MODE_W-1:0] mode;
  logic [7:0] km1;
  logic [1:0] sel, mpe;
  logic [15:0] ovf, unf, clr_bits, lane_alm;
  logic sum_alm, ser_ri, buf_ri, lbr, spd, ilas, pllb, il, srd;
  logic cha, chb, oop, seen;
  amcfa_pkg::amcfa_link_s cfg;
  logic [8:0] fpm;
  logic [5:0] pllm;
  int miscompares = 0;
  int tests_run = 0;
  int cycles = 0;
  // Expected decode per mode code; code 4 is reserved
  logic [0:6] des_tab = 7'h63;
  logic [0:6] val_tab = 7'h7b;
  logic [5:0] rx4_tab [7] = '{6'h10, 6'h08, 6'h10, 6'h08, 6'h00,
    6'h0a, 6'h05};
  logic [4:0] lanes_tab [7] = '{5'h04, 5'h08, 5'h04, 5'h08, 5'h00,
    5'h04, 5'h08};

  amcfa_mode_cfg_fifo_alarm dut (
    .clock(clock), .rst(rst), .link_mode_select(mode),
    .link_enable(en), .frames_per_multiframe_minus_one(km1),
    .auto_reinit_on_buffer_alarm(auto_ri), .input_swap(swap),
    .single_input_select(sel), .cal_done(cal),
    .lane_overflow(ovf), .lane_underflow(unf),
    .alarm_clear_wr(clr_wr), .alarm_clear_bits(clr_bits),
    .lane_buffer_alarm(sum_alm), .per_lane_buffer_alarm(lane_alm),
    .serializer_reinit(ser_ri), .buffer_reinit(buf_ri),
    .link_block_reset(lbr), .serializer_power_down(spd),
    .link_cfg(cfg), .frames_per_multiframe(fpm),
    .multiblocks_per_emb(mpe), .ilas_enable(ilas),
    .pll_mult_x4(pllm), .pll_bypass(pllb), .interleave(il),
    .sample_rate_double(srd), .ch_a_input(cha), .ch_b_input(chb),
    .ch_b_out_of_phase(oop));

  amcfa_rx_model rx (
    .clock(clock), .rst(rst), .ilas_enable(ilas),
    .serializer_power_down(spd), .ilas_seen(seen));

  task automatic wrap_up;
    if (miscompares == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      $display("unexpected %s exp %h got %h", what, exp, got);
      miscompares++;
    end
  endtask

  // One cycle of upset and clear pulses, either or both, then release
  task automatic pulse(logic [15:0] o, logic [15:0] u, logic [15:0] c);
    ovf = o;
    unf = u;
    clr_wr = |c;
    clr_bits = c;
    @(negedge clock);
    ovf = 16'h0;
    unf = 16'h0;
    clr_wr = 1'h0;
    clr_bits = 16'h0;
  endtask

  task automatic cal_pulse;
    @(negedge clock) cal = 1'h1;
    @(negedge clock) cal = 1'h0;
    repeat (2) @(negedge clock);
  endtask

  task automatic t_alarm;
    pulse(16'h0008, 16'h0, 16'h0);
    chk("lane", 32'h8, lane_alm);
    chk("sum", 32'h1, sum_alm);
    pulse(16'h0, 16'h8000, 16'h0);
    chk("lane", 32'h8008, lane_alm);
    // Clear lanes 3 and 15 while lane 15 is hit again: set must win
    pulse(16'h0, 16'h8000, 16'h8008);
    chk("lane", 32'h8000, lane_alm);
    chk("reinit", 32'h0, ser_ri);
    pulse(16'h0, 16'h0, 16'hffff);
    chk("lane", 32'h0, lane_alm);
    chk("sum", 32'h0, sum_alm);
  endtask

  task automatic t_reinit;
    int n;
    int nb;
    n = 0;
    nb = 0;
    en = 1'h1;
    auto_ri = 1'h1;
    @(negedge clock);
    pulse(16'h0001, 16'h0, 16'h0);
    repeat (20) begin
      if (ser_ri === 1'h1 && lbr === 1'h1) n++;
      if (buf_ri === 1'h1) nb++;
      @(negedge clock);
    end
    chk("ser_reinit", amcfa_pkg::REINIT_CYC, n);
    chk("buf_reinit", amcfa_pkg::REINIT_CYC, nb);
    // Second reinit cut short by dropping the link
    pulse(16'h0002, 16'h0, 16'h0);
    chk("ri_start", 32'h1, ser_ri);
    en = 1'h0;
    @(negedge clock);
    chk("ri_stop", 32'h0, ser_ri);
    auto_ri = 1'h0;
    pulse(16'h0, 16'h0, 16'hffff);
  endtask

  task automatic t_mode;
    for (int m = 0; m < 7; m++) begin
      @(negedge clock);
      en = 1'h0;
      mode = m[4:0];
      repeat (2) @(negedge clock);
      chk("pdown", 32'h6, {spd, lbr, ilas});
      chk("valid", val_tab[m], cfg.valid);
      chk("lanes", lanes_tab[m], cfg.lanes);
      chk("des", {3{des_tab[m]}}, {il, srd, cfg.des});
      chk("r_x4", rx4_tab[m], pllm);
      chk("bypass", 32'h0, pllb);
      chk("emb", 32'h0, mpe);
      if (val_tab[m]) begin
        chk("fpm", 32'h10, fpm);
      end
      en = 1'h1;
      repeat (3) @(negedge clock);
      chk("ilas", {2{val_tab[m]}}, {ilas, seen});
    end
    en = 1'h0;
  endtask

  task automatic t_mux;
    mode = 5'h02;
    swap = 1'h1;
    cal_pulse();
    chk("swap", 32'h2, {cha, chb});
    swap = 1'h0;
    repeat (3) @(negedge clock);
    chk("nocal", 32'h2, {cha, chb});
    cal_pulse();
    chk("dual", 32'h2, {cha, chb, oop});
    mode = 5'h00;
    for (int s = 0; s < 3; s++) begin
      sel = s[1:0];
      cal_pulse();
      chk("single", (s == 0) ? 3'h1 : (s == 1) ? 3'h7 : 3'h3,
        {cha, chb, oop});
    end
    // Dual-input single mode keeps the single mode link setup
    chk("dual_in", 32'h3, {cfg.des, cfg.valid});
  endtask

  // Clock and hang guard
  initial begin
    clock = 1'h0;
    forever #25 clock = ~clock;
  end

  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      wrap_up();
    end
  end

  initial begin
    rst = 1'h1;
    en = 1'h0;
    auto_ri = 1'h0;
    swap = 1'h0;
    cal = 1'h0;
    clr_wr = 1'h0;
    mode = 5'h02;
    km1 = 8'h0f;
    sel = 2'h0;
    ovf = 16'h0;
    unf = 16'h0;
    clr_bits = 16'h0;
    repeat (20) @(posedge clock);
    @(negedge clock) rst = 1'h0;
    chk("rst_out", 32'h1, {lane_alm, cha, chb});
    t_alarm();
    t_reinit();
    t_mode();
    t_mux();
    wrap_up();
  end
endmodule
